// ### blom_pkg.sv
// Shared constants, codeword table and helpers for the maintenance link codeword block
// What this block does
// RL1: All-ones alarm drives every line bit one
// RL2: Alarm and loopback codes ride overhead only
// RL3: Link uses overhead bit of alternate frames
// RL4: Codewords and performance data, same both directions
// RL5: Active codeword overwrites performance data
// RL6: Sixteen bits: eight ones, 0xxxxxx0, MSB first
// RL7: Performance data sent when no codeword active
// RL8: Unknown received codewords cause no action
// RL9: Send only listed codes, only when true
// RL10: Priority code held at least one second
// RL11: Suspend at most 100 ms, one second apart
// RL12: Alarm 00000000, retention 01010100 second byte
// RL13: Command codewords repeated at least ten times
// RL14: Act after five matches in ten intervals
// RL15: Line loopback on, off, universal release codes
// RL16: Optional payload loopback on and off codes
// RL17: Customer-reserved codes ignored by network equipment
// RL18: Terminator acts on customer-side loopback code
// RL19: Loopback stays until its release is detected
package blom_pkg;
    // Clock and line timing
    localparam int CLK_HZ      = 40_000_000;
    localparam int LINE_KBPS   = 1544;
    localparam int BIT_CYC     = CLK_HZ / (LINE_KBPS * 1000);
    localparam int ONE_SEC_MS  = 1000;
    localparam int SUSP_MS     = 100;
    localparam int SEC_CYC     = CLK_HZ / 1000 * ONE_SEC_MS;
    localparam int SUSP_CYC_D  = CLK_HZ / 1000 * SUSP_MS;

    // Widths
    localparam int DIV_W  = 5;
    localparam int BIT_W  = 8;
    localparam int FRM_W  = 5;
    localparam int CNT_W  = 26;
    localparam int CODE_W = 4;
    localparam int CW_W   = 16;
    localparam int DET_WIN = 10;

    // Frame geometry: 193 bits per frame, 24 frames per multiframe
    localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(BIT_CYC - 1);
    localparam logic [BIT_W-1:0] BIT_LAST   = 8'hc0;
    localparam logic [BIT_W-1:0] FRAME_BITS = 8'hc1;
    localparam logic [FRM_W-1:0] FRM_LAST   = 5'h17;
    localparam logic [3:0]       CW_LAST    = 4'hf;
    localparam logic [3:0]       REP_INIT   = 4'ha;
    localparam logic [3:0]       DET_MIN    = 4'h5;
    localparam logic [7:0]       CW_LEAD    = 8'hff;
    localparam logic [2:0]       FLAG_LAST  = 3'h7;

    // Codeword indices
    localparam int NCODE = 13;
    localparam logic [CODE_W-1:0] C_FEA  = 4'h0;
    localparam logic [CODE_W-1:0] C_RET  = 4'h1;
    localparam logic [CODE_W-1:0] C_LLA  = 4'h2;
    localparam logic [CODE_W-1:0] C_LLD  = 4'h3;
    localparam logic [CODE_W-1:0] C_PLA  = 4'h4;
    localparam logic [CODE_W-1:0] C_PLD  = 4'h5;
    localparam logic [CODE_W-1:0] C_UNI  = 4'h6;
    localparam logic [CODE_W-1:0] C_RS0  = 4'h7;
    localparam logic [CODE_W-1:0] C_RS4  = 4'hb;
    localparam logic [CODE_W-1:0] C_LBC  = 4'hc;
    localparam logic [CODE_W-1:0] C_NONE = 4'hf;

    // Per-end masks: codes an end may send, codes it acts on
    localparam logic [NCODE-1:0] TERM_TX_MASK  = 13'h1f83;
    localparam logic [NCODE-1:0] TERM_ACT_MASK = 13'h007d;
    localparam logic [NCODE-1:0] NET_TX_MASK   = 13'h007d;
    localparam logic [NCODE-1:0] NET_ACT_MASK  = 13'h1003;

    // Transmit word kinds
    typedef enum logic [1:0] {
        BLOM_W_IDLE = 2'b00,
        BLOM_W_PRIO = 2'b01,
        BLOM_W_CMD  = 2'b10
    } blom_word_t;

    // Second byte of each listed codeword
    function automatic logic [7:0] cw_byte(input logic [CODE_W-1:0] k);
        case (k)
            C_FEA:   cw_byte = 8'h00;
            C_RET:   cw_byte = 8'h54;
            C_LLA:   cw_byte = 8'h70;
            C_LLD:   cw_byte = 8'h1c;
            C_PLA:   cw_byte = 8'h28;
            C_PLD:   cw_byte = 8'h4c;
            C_UNI:   cw_byte = 8'h24;
            4'h7:    cw_byte = 8'h40;
            4'h8:    cw_byte = 8'h60;
            4'h9:    cw_byte = 8'h50;
            4'ha:    cw_byte = 8'h6c;
            4'hb:    cw_byte = 8'h74;
            C_LBC:   cw_byte = 8'h04;
            default: cw_byte = 8'hff;
        endcase
    endfunction : cw_byte

    // Map a received second byte to its index, C_NONE if unlisted
    function automatic logic [CODE_W-1:0] code_index(input logic [7:0] b);
        code_index = C_NONE;
        for (int k = 0; k < NCODE; k++) begin
            if (cw_byte(CODE_W'(k)) == b) code_index = CODE_W'(k);
        end
    endfunction : code_index
endpackage : blom_pkg

// ### blom_link_if.sv
// Primary-rate line between user terminal and network side, one serial stream per direction
`timescale 1ns/1ps
interface blom_link_if;
    logic dn_data;    // Network to terminal line bit
    logic dn_strobe;  // Bit valid, one cycle
    logic dn_fstart;  // First bit of multiframe
    logic up_data;    // Terminal to network line bit
    logic up_strobe;
    logic up_fstart;

    modport term (input dn_data, dn_strobe, dn_fstart, output up_data, up_strobe, up_fstart);
    modport net  (output dn_data, dn_strobe, dn_fstart, input up_data, up_strobe, up_fstart);
endinterface : blom_link_if

// ### blom_terminal.sv
// Codeword engine shared by both ends, and the user terminal end
`timescale 1ns/1ps
module blom_engine import blom_pkg::*; #(
    parameter logic [NCODE-1:0] TX_MASK     = TERM_TX_MASK,
    parameter logic [NCODE-1:0] ACT_MASK    = TERM_ACT_MASK,
    parameter logic [CNT_W-1:0] ONE_SEC_CYC = CNT_W'(SEC_CYC),
    parameter logic [CNT_W-1:0] SUSP_CYC    = CNT_W'(SUSP_CYC_D)
) (
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    output logic                   tx_data_o,
    output logic                   tx_strobe_o,
    output logic                   tx_fstart_o,
    input  wire logic              rx_data_i,
    input  wire logic              rx_strobe_i,
    input  wire logic              rx_fstart_i,
    input  wire logic              all_ones_i,
    input  wire logic              payload_i,
    input  wire logic              ovh_bit_i,
    output logic                   payload_take_o,
    input  wire logic              perf_bit_i,
    input  wire logic              perf_valid_i,
    output logic                   perf_ready_o,
    input  wire logic [1:0]        prio_req_i,
    input  wire logic              susp_req_i,
    output logic                   susp_on_o,
    input  wire logic              cmd_req_i,
    input  wire logic [CODE_W-1:0] cmd_code_i,
    output logic                   cmd_busy_o,
    output logic [NCODE-1:0]       rx_det_o,
    output logic [NCODE-1:0]       rx_hit_o,
    output logic                   rx_all_ones_o
);
    function automatic logic [3:0] ones10(input logic [DET_WIN-1:0] v);
        ones10 = 4'h0;
        for (int i = 0; i < DET_WIN; i++) ones10 = ones10 + {3'h0, v[i]};
    endfunction : ones10

    // Transmit framing state
    logic [DIV_W-1:0]  div;
    logic [BIT_W-1:0]  tbit;
    logic [FRM_W-1:0]  tfrm;
    blom_word_t        word;
    logic [CW_W-1:0]   cw_sr;
    logic [3:0]        cw_pos;
    logic [3:0]        rep;
    logic [CODE_W-1:0] cmd_code;
    logic [2:0]        flag_ph;
    logic              prio_on;
    logic [CODE_W-1:0] prio_code;
    logic [CNT_W-1:0]  hold;
    logic              susp_on;
    logic [CNT_W-1:0]  susp_cnt;
    logic [CNT_W-1:0]  gap_cnt;

    // Decode of the transmit slot
    wire               tick     = ce_i && (div == DIV_LAST);
    wire               tx_mslot = (tbit == '0) && !tfrm[0];                      // see RL3
    wire [1:0]         req      = prio_req_i & {TX_MASK[C_RET], TX_MASK[C_FEA]}; // see RL9
    wire [CODE_W-1:0]  req_code = req[0] ? C_FEA : C_RET;                        // see RL12
    wire               prio_send = prio_on && !susp_on;
    wire               flag_bit = (flag_ph != 3'h0) && (flag_ph != FLAG_LAST);
    wire               at_bound = (word == BLOM_W_IDLE) || (cw_pos == CW_LAST);
    wire               m_bit    = (word != BLOM_W_IDLE) ? cw_sr[CW_W-1] :       // see RL5, RL6
                                  (perf_valid_i ? perf_bit_i : flag_bit);        // see RL7
    wire               f_bit    = tx_mslot ? m_bit : ovh_bit_i;                  // see RL2
    wire               next_bit = all_ones_i ? 1'b1 : ((tbit == '0) ? f_bit : payload_i); // see RL1
    wire               m_take   = tick && tx_mslot;

    assign perf_ready_o   = m_take && (word == BLOM_W_IDLE) && !all_ones_i;
    assign payload_take_o = tick && (tbit != '0);
    assign cmd_busy_o     = (rep != 4'h0);
    assign susp_on_o      = susp_on;

    // Bit clock divider and line bit register
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            div         <= '0;
            tbit        <= '0;
            tfrm        <= '0;
            tx_data_o   <= 1'b0;
            tx_strobe_o <= 1'b0;
            tx_fstart_o <= 1'b0;
        end else if (ce_i) begin
            div         <= tick ? '0 : div + DIV_W'(1);
            tx_strobe_o <= tick;
            tx_fstart_o <= tick && (tbit == '0) && (tfrm == '0);
            if (tick) begin
                tx_data_o <= next_bit;
                tbit      <= (tbit == BIT_LAST) ? '0 : tbit + BIT_W'(1);
                if (tbit == BIT_LAST) tfrm <= (tfrm == FRM_LAST) ? '0 : tfrm + FRM_W'(1);
            end
        end
    end

    // Codeword sequencer: priority first, then queued command repeats
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            word     <= BLOM_W_IDLE;
            cw_sr    <= '0;
            cw_pos   <= '0;
            rep      <= '0;
            cmd_code <= '0;
            flag_ph  <= '0;
        end else if (ce_i) begin
            if (cmd_req_i && (rep == 4'h0) && (cmd_code_i < CODE_W'(NCODE)) && TX_MASK[cmd_code_i]) begin
                rep      <= REP_INIT;                                  // see RL9, RL13
                cmd_code <= cmd_code_i;
            end
            if (m_take) begin
                if (word == BLOM_W_IDLE && !perf_valid_i) flag_ph <= flag_ph + 3'h1;
                if (at_bound) begin
                    cw_pos <= '0;
                    if (prio_send) begin
                        word  <= BLOM_W_PRIO;                          // see RL10
                        cw_sr <= {CW_LEAD, cw_byte(prio_code)};
                    end else if (rep != 4'h0) begin
                        word  <= BLOM_W_CMD;
                        cw_sr <= {CW_LEAD, cw_byte(cmd_code)};
                        rep   <= rep - 4'h1;                           // see RL13
                    end else begin
                        word  <= BLOM_W_IDLE;
                    end
                end else begin
                    cw_pos <= cw_pos + 4'h1;
                    cw_sr  <= {cw_sr[CW_W-2:0], 1'b0};                 // see RL6
                end
            end
        end
    end

    // Priority hold of at least one second, and limited suspension
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prio_on   <= 1'b0;
            prio_code <= C_FEA;
            hold      <= '0;
            susp_on   <= 1'b0;
            susp_cnt  <= '0;
            gap_cnt   <= '0;
        end else if (ce_i) begin
            if ((req != 2'b00) && (!prio_on || prio_code != req_code)) begin
                prio_on   <= 1'b1;
                prio_code <= req_code;
                hold      <= ONE_SEC_CYC;                              // see RL10
            end else begin
                if (hold != '0) hold <= hold - CNT_W'(1);
                if ((req == 2'b00) && (hold == '0)) prio_on <= 1'b0;   // see RL9, RL10
            end
            if (gap_cnt != '0) gap_cnt <= gap_cnt - CNT_W'(1);
            if (!susp_on && prio_on && susp_req_i && (gap_cnt == '0)) begin
                susp_on  <= 1'b1;                                      // see RL11
                susp_cnt <= SUSP_CYC;
                gap_cnt  <= ONE_SEC_CYC;
            end else if (susp_on) begin
                if ((susp_cnt == '0) || !susp_req_i) susp_on <= 1'b0;  // see RL11
                else susp_cnt <= susp_cnt - CNT_W'(1);
            end
        end
    end

    // Receive framing and codeword interval tracking
    logic [BIT_W-1:0] rbit;
    logic [FRM_W-1:0] rfrm;
    logic [CW_W-1:0]  rx_sr;
    logic [3:0]       rx_pos;
    logic             locked;
    logic [BIT_W-1:0] ones_run;

    wire              rx_mslot = rx_strobe_i && (rx_fstart_i || ((rbit == '0) && !rfrm[0])); // see RL3
    wire [CW_W-1:0]   rx_word  = {rx_sr[CW_W-2:0], rx_data_i};
    wire              cw_ok    = (rx_word[15:8] == CW_LEAD) && !rx_word[7] && !rx_word[0];   // see RL6
    wire              rx_end   = rx_mslot && (locked ? (rx_pos == CW_LAST) : cw_ok);
    wire [CODE_W-1:0] rx_code  = cw_ok ? code_index(rx_word[7:0]) : C_NONE;                // see RL8

    assign rx_all_ones_o = (ones_run == FRAME_BITS);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rbit     <= '0;
            rfrm     <= '0;
            rx_sr    <= '0;
            rx_pos   <= '0;
            locked   <= 1'b0;
            ones_run <= '0;
        end else if (ce_i && rx_strobe_i) begin
            rbit <= rx_fstart_i ? BIT_W'(1) : ((rbit == BIT_LAST) ? '0 : rbit + BIT_W'(1));
            if (rx_fstart_i) rfrm <= '0;
            else if (rbit == BIT_LAST) rfrm <= (rfrm == FRM_LAST) ? '0 : rfrm + FRM_W'(1);
            ones_run <= !rx_data_i ? '0 : (rx_all_ones_o ? ones_run : ones_run + BIT_W'(1));
            if (rx_mslot) begin
                rx_sr  <= rx_word;
                rx_pos <= rx_end ? 4'h0 : rx_pos + 4'h1;
                if (rx_end) locked <= cw_ok;
            end
        end
    end

    // Five-of-ten match window per codeword that this end acts on
    logic [DET_WIN-1:0] hist [NCODE];
    logic [NCODE-1:0]   det_q;

    for (genvar k = 0; k < NCODE; k++) begin : g_det
        if (ACT_MASK[k]) begin : g_on
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    hist[k]  <= '0;
                    det_q[k] <= 1'b0;
                end else if (ce_i) begin
                    if (rx_end) hist[k] <= {hist[k][DET_WIN-2:0], rx_code == CODE_W'(k)}; // see RL14
                    det_q[k] <= rx_det_o[k];
                end
            end
            assign rx_det_o[k] = (ones10(hist[k]) >= DET_MIN);          // see RL14
        end else begin : g_off
            assign hist[k]     = '0;                                    // see RL8, RL17
            assign det_q[k]    = 1'b0;
            assign rx_det_o[k] = 1'b0;
        end
        assign rx_hit_o[k] = ce_i && rx_det_o[k] && !det_q[k];
    end
endmodule : blom_engine

module blom_terminal import blom_pkg::*; #(
    parameter logic [CNT_W-1:0] ONE_SEC_CYC   = CNT_W'(SEC_CYC),
    parameter logic [CNT_W-1:0] SUSP_CYC      = CNT_W'(SUSP_CYC_D),
    parameter bit               PAYLOAD_LB_EN = 1'b1
) (
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    blom_link_if.term              lk,
    input  wire logic              all_ones_alarm_i,
    input  wire logic              payload_i,
    input  wire logic              ovh_bit_i,
    output logic                   payload_take_o,
    input  wire logic              perf_bit_i,
    input  wire logic              perf_valid_i,
    output logic                   perf_ready_o,
    input  wire logic              far_end_alarm_i,
    input  wire logic              lb_retain_en_i,
    input  wire logic              susp_req_i,
    output logic                   susp_on_o,
    input  wire logic              cmd_req_i,
    input  wire logic [CODE_W-1:0] cmd_code_i,
    output logic                   cmd_busy_o,
    output logic                   line_lb_o,
    output logic                   payload_lb_o,
    output logic                   rx_far_end_alarm_o,
    output logic                   rx_all_ones_o
);
    logic [NCODE-1:0] det;
    logic [NCODE-1:0] hit;

    // Retention is only true while a loopback is actually held
    wire [1:0] prio_req = {lb_retain_en_i && (line_lb_o || payload_lb_o), far_end_alarm_i}; // see RL9

    blom_engine #(
        .TX_MASK     (TERM_TX_MASK),
        .ACT_MASK    (TERM_ACT_MASK),
        .ONE_SEC_CYC (ONE_SEC_CYC),
        .SUSP_CYC    (SUSP_CYC)
    ) blom_engine_inst (  // Same engine both ways, see RL4
        .mclk_i         (mclk_i),
        .srst_i         (srst_i),
        .ce_i           (ce_i),
        .tx_data_o      (lk.up_data),
        .tx_strobe_o    (lk.up_strobe),
        .tx_fstart_o    (lk.up_fstart),
        .rx_data_i      (lk.dn_data),
        .rx_strobe_i    (lk.dn_strobe),
        .rx_fstart_i    (lk.dn_fstart),
        .all_ones_i     (all_ones_alarm_i),
        .payload_i      (payload_i),
        .ovh_bit_i      (ovh_bit_i),
        .payload_take_o (payload_take_o),
        .perf_bit_i     (perf_bit_i),
        .perf_valid_i   (perf_valid_i),
        .perf_ready_o   (perf_ready_o),
        .prio_req_i     (prio_req),
        .susp_req_i     (susp_req_i),
        .susp_on_o      (susp_on_o),
        .cmd_req_i      (cmd_req_i),
        .cmd_code_i     (cmd_code_i),
        .cmd_busy_o     (cmd_busy_o),
        .rx_det_o       (det),
        .rx_hit_o       (hit),
        .rx_all_ones_o  (rx_all_ones_o)
    );

    assign rx_far_end_alarm_o = det[C_FEA];

    // Loopback state, held until its own or the universal release
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            line_lb_o    <= 1'b0;
            payload_lb_o <= 1'b0;
        end else if (ce_i) begin
            if (hit[C_LLA]) line_lb_o <= 1'b1;                                    // see RL15
            else if (hit[C_LLD] || hit[C_UNI]) line_lb_o <= 1'b0;                 // see RL19
            if (hit[C_PLA] && PAYLOAD_LB_EN) payload_lb_o <= 1'b1;                // see RL16
            else if (hit[C_PLD] || hit[C_UNI]) payload_lb_o <= 1'b0;              // see RL19
        end
    end
endmodule : blom_terminal

// ### blom_network.sv
// Network-side end: sends loopback commands, acts on the customer-side loopback code
`timescale 1ns/1ps
module blom_network import blom_pkg::*; #(
    parameter logic [CNT_W-1:0] ONE_SEC_CYC = CNT_W'(SEC_CYC),
    parameter logic [CNT_W-1:0] SUSP_CYC    = CNT_W'(SUSP_CYC_D)
) (
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    blom_link_if.net               lk,
    input  wire logic              all_ones_alarm_i,
    input  wire logic              payload_i,
    input  wire logic              ovh_bit_i,
    output logic                   payload_take_o,
    input  wire logic              perf_bit_i,
    input  wire logic              perf_valid_i,
    output logic                   perf_ready_o,
    input  wire logic              far_end_alarm_i,
    input  wire logic              susp_req_i,
    output logic                   susp_on_o,
    input  wire logic              cmd_req_i,
    input  wire logic [CODE_W-1:0] cmd_code_i,
    output logic                   cmd_busy_o,
    input  wire logic              lbc_clear_i,
    output logic                   cust_lb_o,
    output logic                   rx_far_end_alarm_o,
    output logic                   rx_retention_o,
    output logic                   rx_all_ones_o
);
    logic [NCODE-1:0] det;
    logic [NCODE-1:0] hit;

    blom_engine #(
        .TX_MASK     (NET_TX_MASK),
        .ACT_MASK    (NET_ACT_MASK),
        .ONE_SEC_CYC (ONE_SEC_CYC),
        .SUSP_CYC    (SUSP_CYC)
    ) blom_engine_inst (
        .mclk_i         (mclk_i),
        .srst_i         (srst_i),
        .ce_i           (ce_i),
        .tx_data_o      (lk.dn_data),
        .tx_strobe_o    (lk.dn_strobe),
        .tx_fstart_o    (lk.dn_fstart),
        .rx_data_i      (lk.up_data),
        .rx_strobe_i    (lk.up_strobe),
        .rx_fstart_i    (lk.up_fstart),
        .all_ones_i     (all_ones_alarm_i),
        .payload_i      (payload_i),
        .ovh_bit_i      (ovh_bit_i),
        .payload_take_o (payload_take_o),
        .perf_bit_i     (perf_bit_i),
        .perf_valid_i   (perf_valid_i),
        .perf_ready_o   (perf_ready_o),
        .prio_req_i     ({1'b0, far_end_alarm_i}),
        .susp_req_i     (susp_req_i),
        .susp_on_o      (susp_on_o),
        .cmd_req_i      (cmd_req_i),
        .cmd_code_i     (cmd_code_i),
        .cmd_busy_o     (cmd_busy_o),
        .rx_det_o       (det),
        .rx_hit_o       (hit),
        .rx_all_ones_o  (rx_all_ones_o)
    );

    assign rx_far_end_alarm_o = det[C_FEA];
    assign rx_retention_o     = det[C_RET];

    // Customer-side loopback; detection wins over a same-cycle clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cust_lb_o <= 1'b0;
        end else if (ce_i) begin
            if (hit[C_LBC]) cust_lb_o <= 1'b1;                 // see RL18
            else if (lbc_clear_i) cust_lb_o <= 1'b0;
        end
    end
endmodule : blom_network

// ### blom_link_monitor.sv
// Link wire monitor: bit spacing, multiframe marker, data hold
`timescale 1ns/1ps
module blom_link_monitor (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic dn_data,
    input wire logic dn_strobe,
    input wire logic dn_fstart,
    input wire logic up_data,
    input wire logic up_strobe,
    input wire logic up_fstart
);
    logic [1:0]  stb, fst, seen, fseen;
    logic [4:0]  gap [2];
    logic [12:0] nb  [2];
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // Both directions as two-entry vectors
    assign stb = {up_strobe, dn_strobe};
    assign fst = {up_fstart, dn_fstart};
    // Cycles since last strobe, strobes since multiframe marker
    always_ff @(posedge mclk_i) begin
        for (int d = 0; d < 2; d++) begin
            if (srst_i) begin
                gap[d] <= 5'h0;
                nb[d] <= 13'h0;
                seen[d] <= 1'b0;
                fseen[d] <= 1'b0;
            end else begin
                gap[d] <= stb[d] ? 5'h0 : gap[d] + 5'h1;
                seen[d] <= seen[d] | stb[d];
                fseen[d] <= fseen[d] | fst[d];
                nb[d] <= fst[d] ? 13'h1 : nb[d] + 13'(stb[d]);
            end
        end
    end
    a_dn_bit_gap: assert property (stb[0] && seen[0] |-> gap[0] == 5'h18) else $error("dn gap");
    a_up_bit_gap: assert property (stb[1] && seen[1] |-> gap[1] == 5'h18) else $error("up gap");
    a_dn_mark_strobe: assert property (dn_fstart |-> dn_strobe) else $error("dn mark");
    a_up_mark_strobe: assert property (up_fstart |-> up_strobe) else $error("up mark");
    a_dn_data_hold: assert property (!dn_strobe |-> $stable(dn_data)) else $error("dn hold");
    a_up_data_hold: assert property (!up_strobe |-> $stable(up_data)) else $error("up hold");
    a_dn_frame_len: assert property (stb[0] && fseen[0] |-> fst[0] == (nb[0] == 13'h1218)) else $error("dn mf");
    a_up_frame_len: assert property (stb[1] && fseen[1] |-> fst[1] == (nb[1] == 13'h1218)) else $error("up mf");
endmodule : blom_link_monitor

// ### blom_link_bench.sv
// Bench: terminal and network ends joined across the link
`timescale 1ns/1ps
module blom_link_bench import blom_pkg::*;;
    logic mclk = 1'b0, srst = 1'b1, hi = 1'b1, lo = 1'b0;
    logic t_ao = 1'b0, n_ao = 1'b0, t_fea = 1'b0, n_fea = 1'b0, t_req = 1'b0, n_req = 1'b0, n_clr = 1'b0;
    logic [CODE_W-1:0] t_code = C_LBC, n_code = C_LLA;
    logic t_busy, n_busy, line_lb, t_rx_ao, n_cust, n_rx_fea;
    logic [15:0] up_sr = 16'h0;
    int up_k = 0, n_mismatch = 0, n_compared = 0, i;
    blom_link_if lk ();
    blom_terminal #(.ONE_SEC_CYC(CNT_W'(400)), .SUSP_CYC(CNT_W'(40))) blom_terminal_inst (
        .mclk_i(mclk), .srst_i(srst), .ce_i(hi), .lk(lk), .all_ones_alarm_i(t_ao), .payload_i(lo),
        .ovh_bit_i(lo), .payload_take_o(), .perf_bit_i(lo), .perf_valid_i(hi), .perf_ready_o(),
        .far_end_alarm_i(t_fea), .lb_retain_en_i(lo), .susp_req_i(lo), .susp_on_o(), .cmd_req_i(t_req),
        .cmd_code_i(t_code), .cmd_busy_o(t_busy), .line_lb_o(line_lb), .payload_lb_o(),
        .rx_far_end_alarm_o(), .rx_all_ones_o(t_rx_ao));
    blom_network #(.ONE_SEC_CYC(CNT_W'(400)), .SUSP_CYC(CNT_W'(40))) blom_network_inst (
        .mclk_i(mclk), .srst_i(srst), .ce_i(hi), .lk(lk), .all_ones_alarm_i(n_ao), .payload_i(lo),
        .ovh_bit_i(lo), .payload_take_o(), .perf_bit_i(lo), .perf_valid_i(hi), .perf_ready_o(),
        .far_end_alarm_i(n_fea), .susp_req_i(lo), .susp_on_o(), .cmd_req_i(n_req), .cmd_code_i(n_code),
        .cmd_busy_o(n_busy), .lbc_clear_i(n_clr), .cust_lb_o(n_cust), .rx_far_end_alarm_o(n_rx_fea),
        .rx_retention_o(), .rx_all_ones_o());
    blom_link_monitor blom_link_monitor_inst (.mclk_i(mclk), .srst_i(srst), .dn_data(lk.dn_data),
        .dn_strobe(lk.dn_strobe), .dn_fstart(lk.dn_fstart), .up_data(lk.up_data),
        .up_strobe(lk.up_strobe), .up_fstart(lk.up_fstart));
    always #12.5 mclk = ~mclk;
    // Shift in upstream link bits, overhead bit of every second frame
    always @(posedge mclk) begin
        if (lk.up_strobe) begin
            up_k = lk.up_fstart ? 0 : up_k;
            if (up_k % 386 == 0) up_sr = {up_sr[14:0], lk.up_data};
            up_k++;
        end
    end
    task automatic end_sim();
        if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got, input bit stop);
        n_compared++;
        if (exp !== got) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            if (stop) end_sim();
        end
    endtask : chk
    task automatic net_cmd(input logic [CODE_W-1:0] c);
        n_code = c;
        n_req = 1'b1;
        @(negedge mclk);
        n_req = 1'b0;
        @(negedge mclk);
    endtask : net_cmd
    // All-ones downstream: every bit one, terminal reports it, then clears
    task automatic t_all_ones();
        n_ao = 1'b1;
        repeat (30) @(negedge mclk);
        repeat (4825) begin
            @(negedge mclk);
            if (lk.dn_strobe) chk("dn_data", 16'h1, lk.dn_data, 1'b0);
        end
        repeat (30) @(negedge mclk);
        chk("t_rx_ao", 16'h1, t_rx_ao, 1'b0);
        n_ao = 1'b0;
        repeat (60) @(negedge mclk);
        chk("t_rx_ao", 16'h0, t_rx_ao, 1'b0);
    endtask : t_all_ones
    // Network commands: reserved code refused, line loopback on, universal off
    task automatic t_line_lb();
        net_cmd(C_RS0);
        chk("n_busy", 16'h0, n_busy, 1'b0);
        net_cmd(C_LLA);
        chk("n_busy", 16'h1, n_busy, 1'b0);
        for (i = 0; i < 2000000 && !line_lb; i++) @(negedge mclk);
        chk("line_lb", 16'h1, line_lb, 1'b1);
        for (i = 0; i < 2000000 && n_busy; i++) @(negedge mclk);
        chk("n_busy", 16'h0, n_busy, 1'b1);
        chk("line_lb", 16'h1, line_lb, 1'b0);
        net_cmd(C_UNI);
        for (i = 0; i < 2000000 && line_lb; i++) @(negedge mclk);
        chk("line_lb", 16'h0, line_lb, 1'b1);
    endtask : t_line_lb
    // Terminal sends loopback C: not before five intervals, then set, then cleared
    task automatic t_cust_lb();
        t_req = 1'b1;
        @(negedge mclk);
        t_req = 1'b0;
        repeat (600000) @(negedge mclk);
        chk("n_cust", 16'h0, n_cust, 1'b0);
        for (i = 0; i < 2000000 && !n_cust; i++) @(negedge mclk);
        chk("n_cust", 16'h1, n_cust, 1'b1);
        chk("t_busy", 16'h1, t_busy, 1'b0);
        n_clr = 1'b1;
        @(negedge mclk);
        n_clr = 1'b0;
        @(negedge mclk);
        chk("n_cust", 16'h0, n_cust, 1'b0);
        for (i = 0; i < 2000000 && t_busy; i++) @(negedge mclk);
        chk("t_busy", 16'h0, t_busy, 1'b1);
    endtask : t_cust_lb
    // Idle link carries performance zeros; alarm word overrides and is detected
    task automatic t_far_alarm();
        repeat (300000) @(negedge mclk);
        chk("up_sr", 16'h0, up_sr, 1'b0);
        t_fea = 1'b1;
        for (i = 0; i < 700000 && up_sr !== 16'hff00; i++) @(negedge mclk);
        chk("up_sr", 16'hff00, up_sr, 1'b1);
        for (i = 0; i < 1500000 && !n_rx_fea; i++) @(negedge mclk);
        chk("n_rx_fea", 16'h1, n_rx_fea, 1'b1);
    endtask : t_far_alarm
    initial begin
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        t_all_ones();
        t_line_lb();
        t_cust_lb();
        t_far_alarm();
        end_sim();
    end
endmodule : blom_link_bench
